//--- verilog/tcsp_top.sv
// Purpose: control and status pins plus management controller of an optical module
// Assumes: scl and sda inputs are already synchronous to clock_i
// Notes: open-drain pins are driven low only, enable high means pulling low
`default_nettype none
module tcsp_top
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic transmit_off_request_i,
	input wire logic deselect_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic interrupt_o,
	output logic interrupt_oe_o,
	output logic laser_enable_o,
	output logic rx_signal_lost_o,
	output logic module_fault_flag_o,
	input wire logic tx_unlock_i,
	input wire logic laser_fault_i,
	input wire logic rx_unlock_i,
	input wire logic [7:0] temp_i,
	input wire logic [7:0] bias_i,
	input wire logic [7:0] tx_power_i,
	input wire logic [7:0] rx_power_i,
	input wire logic [7:0] supply_i,
	output logic cfg_wr_o,
	output logic [1:0] cfg_unit_o,
	output logic [3:0] cfg_addr_o,
	output logic [7:0] cfg_data_o,
	output logic ready_o
);
	// ****************************************
	// init table for the attached units
	// ****************************************
	function automatic logic [13:0] init_word(input logic [tcsp_pkg::INIT_IDX_W-1:0] idx);
		logic [13:0] w;
		w = '0;
		unique case (idx)
			3'h0: w = {tcsp_pkg::UNIT_LASER, 4'h0, 8'h40};
			3'h1: w = {tcsp_pkg::UNIT_LASER, 4'h1, 8'h30};
			3'h2: w = {tcsp_pkg::UNIT_LIMAMP, 4'h0, 8'h08};
			3'h3: w = {tcsp_pkg::UNIT_LIMAMP, 4'h1, 8'h01};
			3'h4: w = {tcsp_pkg::UNIT_CDR, 4'h0, 8'h03};
			default: w = {tcsp_pkg::UNIT_CDR, 4'h1, 8'h00};
		endcase
		return w;
	endfunction

	// ****************************************
	// controller state
	// ****************************************
	tcsp_pkg::tcsp_ctl_type ctl_r, ctl_nxt;
	logic [tcsp_pkg::INIT_IDX_W-1:0] init_idx_r, init_idx_nxt;
	logic cfg_wr_r, cfg_wr_nxt;
	logic [13:0] cfg_word_r, cfg_word_nxt;
	logic [tcsp_pkg::MON_CNT_W-1:0] mon_cnt_r, mon_cnt_nxt;
	logic mon_tick;
	logic [7:0] temp_r, bias_r, txp_r, rxp_r, sup_r;
	logic [7:0] temp_nxt, bias_nxt, txp_nxt, rxp_nxt, sup_nxt;

	// init walks the table once, then the monitor samples on a divided tick
	always_comb
	begin
		ctl_nxt = ctl_r;
		init_idx_nxt = init_idx_r;
		cfg_wr_nxt = 1'b0;
		cfg_word_nxt = cfg_word_r;
		mon_cnt_nxt = mon_cnt_r;
		mon_tick = 1'b0;
		temp_nxt = temp_r;
		bias_nxt = bias_r;
		txp_nxt = txp_r;
		rxp_nxt = rxp_r;
		sup_nxt = sup_r;
		unique case (ctl_r)
			tcsp_pkg::CTL_INIT:
			begin
				cfg_wr_nxt = 1'b1; // R9
				cfg_word_nxt = init_word(init_idx_r); // R9
				init_idx_nxt = init_idx_r + 3'h1;
				if (init_idx_r == 3'(tcsp_pkg::INIT_COUNT - 1))
					ctl_nxt = tcsp_pkg::CTL_RUN;
			end
			tcsp_pkg::CTL_RUN:
			begin
				if (mon_cnt_r == 8'(tcsp_pkg::MON_PERIOD_CYCLES - 1))
				begin
					mon_cnt_nxt = '0;
					mon_tick = 1'b1;
				end
				else
					mon_cnt_nxt = mon_cnt_r + 8'h01;
				if (mon_tick)
				begin
					temp_nxt = temp_i; // R9
					bias_nxt = bias_i;
					txp_nxt = tx_power_i;
					rxp_nxt = rx_power_i;
					sup_nxt = supply_i;
				end
			end
		endcase
	end

	// controller registers
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			ctl_r <= tcsp_pkg::CTL_INIT;
			init_idx_r <= '0;
			cfg_wr_r <= 1'b0;
			cfg_word_r <= '0;
			mon_cnt_r <= '0;
			temp_r <= '0;
			bias_r <= '0;
			txp_r <= '0;
			rxp_r <= '0;
			sup_r <= '0;
		end
		else
		begin
			ctl_r <= ctl_nxt;
			init_idx_r <= init_idx_nxt;
			cfg_wr_r <= cfg_wr_nxt;
			cfg_word_r <= cfg_word_nxt;
			mon_cnt_r <= mon_cnt_nxt;
			temp_r <= temp_nxt;
			bias_r <= bias_nxt;
			txp_r <= txp_nxt;
			rxp_r <= rxp_nxt;
			sup_r <= sup_nxt;
		end
	end

	// ****************************************
	// pin status logic
	// ****************************************
	logic [7:0] control_r, control_nxt;
	logic tx_off_r, tx_off_nxt;
	logic los_r, los_nxt;
	logic fault_r, fault_nxt;

	// one-cycle path keeps laser shut-off far inside its time budget
	always_comb
	begin
		tx_off_nxt = transmit_off_request_i | control_r[tcsp_pkg::CTRL_SOFT_TX_OFF]; // R1 R2
		fault_nxt = tx_unlock_i | laser_fault_i | rx_unlock_i; // R4 R5
		los_nxt = los_r;
		// hysteresis stops the flag chattering near the threshold
		if (rx_power_i < tcsp_pkg::LOS_ASSERT_CODE)
			los_nxt = 1'b1; // R3
		else if (rx_power_i > tcsp_pkg::LOS_DEASSERT_CODE)
			los_nxt = 1'b0; // R3
	end

	// status registers; laser starts off until the first evaluated cycle
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			tx_off_r <= 1'b1;
			los_r <= 1'b1;
			fault_r <= 1'b0;
		end
		else
		begin
			tx_off_r <= tx_off_nxt;
			los_r <= los_nxt;
			fault_r <= fault_nxt;
		end
	end

	// ****************************************
	// cause latch
	// ****************************************
	logic [tcsp_pkg::NUM_CAUSES-1:0] cause;
	logic cause_any;
	logic cause_clear;

	tcsp_cause_latch u_cause
	(
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.cond_i({tx_off_r, rx_unlock_i, laser_fault_i, tx_unlock_i, los_r}),
		.clear_i(cause_clear),
		.cause_o(cause),
		.any_o(cause_any)
	);

	// ****************************************
	// two-wire management slave
	// ****************************************
	tcsp_pkg::tcsp_tw_type tw_r, tw_nxt;
	logic scl_q_r, sda_q_r;
	logic [3:0] bits_r, bits_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [2:0] ptr_r, ptr_nxt;
	logic rw_r, rw_nxt;
	logic oe_r, oe_nxt;
	logic scl_rise, scl_fall, start_c, stop_c;
	logic [7:0] rd_byte;

	assign scl_rise = scl_i & ~scl_q_r;
	assign scl_fall = ~scl_i & scl_q_r;
	assign start_c = scl_i & scl_q_r & sda_q_r & ~sda_i;
	assign stop_c = scl_i & scl_q_r & ~sda_q_r & sda_i;

	// read map; cause byte is cleared by reading it
	always_comb
	begin
		unique case (ptr_r)
			tcsp_pkg::IDX_CAUSE: rd_byte = {3'h0, cause}; // R8
			tcsp_pkg::IDX_STATUS: rd_byte = {4'h0, ready_o, fault_r, los_r, tx_off_r};
			tcsp_pkg::IDX_TEMP: rd_byte = temp_r; // R9
			tcsp_pkg::IDX_BIAS: rd_byte = bias_r;
			tcsp_pkg::IDX_TXPWR: rd_byte = txp_r;
			tcsp_pkg::IDX_RXPWR: rd_byte = rxp_r;
			tcsp_pkg::IDX_SUPPLY: rd_byte = sup_r;
			tcsp_pkg::IDX_CONTROL: rd_byte = control_r;
		endcase
	end

	// bits are taken on scl rise, sda changes on scl fall except the release at start, stop or deselect
	always_comb
	begin
		tw_nxt = tw_r;
		bits_nxt = bits_r;
		shift_nxt = shift_r;
		ptr_nxt = ptr_r;
		rw_nxt = rw_r;
		oe_nxt = oe_r;
		control_nxt = control_r;
		cause_clear = 1'b0;
		if (deselect_i || stop_c)
		begin
			tw_nxt = tcsp_pkg::TW_IDLE; // R6 R7
			oe_nxt = 1'b0; // R7
		end
		else if (start_c)
		begin
			tw_nxt = tcsp_pkg::TW_ADDR; // R6
			bits_nxt = '0;
			oe_nxt = 1'b0;
		end
		else
		begin
			unique case (tw_r)
				tcsp_pkg::TW_IDLE:
				begin
					oe_nxt = 1'b0;
				end
				tcsp_pkg::TW_ADDR, tcsp_pkg::TW_PTR, tcsp_pkg::TW_WR:
				begin
					if (scl_rise)
					begin
						shift_nxt = {shift_r[6:0], sda_i};
						bits_nxt = bits_r + 4'h1;
					end
					else if (scl_fall && bits_r == 4'h8)
					begin
						oe_nxt = 1'b1;
						if (tw_r == tcsp_pkg::TW_ADDR)
						begin
							rw_nxt = shift_r[0];
							if (shift_r[7:1] == tcsp_pkg::DEV_ADDR)
								tw_nxt = tcsp_pkg::TW_ADDR_ACK;
							else
							begin
								tw_nxt = tcsp_pkg::TW_IDLE;
								oe_nxt = 1'b0;
							end
						end
						else if (tw_r == tcsp_pkg::TW_PTR)
						begin
							ptr_nxt = shift_r[2:0];
							tw_nxt = tcsp_pkg::TW_PTR_ACK;
						end
						else
						begin
							if (ptr_r == tcsp_pkg::IDX_CONTROL)
								control_nxt = shift_r;
							ptr_nxt = ptr_r + 3'h1;
							tw_nxt = tcsp_pkg::TW_WR_ACK;
						end
					end
				end
				tcsp_pkg::TW_ADDR_ACK, tcsp_pkg::TW_PTR_ACK, tcsp_pkg::TW_WR_ACK, tcsp_pkg::TW_RD_NEXT:
				begin
					if (scl_fall)
					begin
						bits_nxt = '0;
						oe_nxt = 1'b0;
						if (tw_r == tcsp_pkg::TW_ADDR_ACK && !rw_r)
							tw_nxt = tcsp_pkg::TW_PTR;
						else if (tw_r == tcsp_pkg::TW_ADDR_ACK || tw_r == tcsp_pkg::TW_RD_NEXT)
						begin
							tw_nxt = tcsp_pkg::TW_RD;
							shift_nxt = rd_byte;
							oe_nxt = ~rd_byte[7];
							ptr_nxt = ptr_r + 3'h1;
							cause_clear = (ptr_r == tcsp_pkg::IDX_CAUSE); // R8
						end
						else
							tw_nxt = tcsp_pkg::TW_WR;
					end
				end
				tcsp_pkg::TW_RD:
				begin
					if (scl_rise)
						bits_nxt = bits_r + 4'h1;
					else if (scl_fall)
					begin
						if (bits_r == 4'h8)
						begin
							oe_nxt = 1'b0;
							tw_nxt = tcsp_pkg::TW_RD_ACK;
						end
						else
						begin
							shift_nxt = {shift_r[6:0], 1'b0};
							oe_nxt = ~shift_r[6];
						end
					end
				end
				tcsp_pkg::TW_RD_ACK:
				begin
					// host nack ends the read, ack asks for the next byte
					if (scl_rise)
						tw_nxt = sda_i ? tcsp_pkg::TW_IDLE : tcsp_pkg::TW_RD_NEXT;
				end
			endcase
		end
	end

	// two-wire registers
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			tw_r <= tcsp_pkg::TW_IDLE;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			bits_r <= '0;
			shift_r <= '0;
			ptr_r <= '0;
			rw_r <= 1'b0;
			oe_r <= 1'b0;
			control_r <= tcsp_pkg::CONTROL_RESET;
		end
		else
		begin
			tw_r <= tw_nxt;
			scl_q_r <= scl_i;
			sda_q_r <= sda_i;
			bits_r <= bits_nxt;
			shift_r <= shift_nxt;
			ptr_r <= ptr_nxt;
			rw_r <= rw_nxt;
			oe_r <= oe_nxt;
			control_r <= control_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign sda_o = 1'b0;
	assign sda_oe_o = oe_r; // R7
	assign interrupt_o = 1'b0;
	assign interrupt_oe_o = cause_any; // R8
	assign laser_enable_o = ~tx_off_r; // R1
	assign rx_signal_lost_o = los_r; // R3
	assign module_fault_flag_o = fault_r; // R4
	assign cfg_wr_o = cfg_wr_r;
	assign cfg_unit_o = cfg_word_r[13:12];
	assign cfg_addr_o = cfg_word_r[11:8];
	assign cfg_data_o = cfg_word_r[7:0];
	assign ready_o = (ctl_r == tcsp_pkg::CTL_RUN);
endmodule
`default_nettype wire

//--- verilog/tcsp_pkg.sv
// Purpose: shared constants for the transceiver control and status pin logic
// Assumes: one 250 MHz clock; all pins are synchronous to it
// Notes: management addresses, thresholds and init values are plain defaults
//
// Summary of operation
// R1: transmit-off request high turns laser off
// R2: laser off within 10 us of request
// R3: signal-lost high when received power too low
// R4: fault output is OR of three fault sources
// R5: fault high means data is invalid
// R6: serial commands answered only while select low
// R7: deselected: ignore serial traffic, data line released
// R8: interrupt on important condition, cause readable serially
// R9: controller initialises units, then monitors and reports
`default_nettype none
package tcsp_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 4;
	localparam int TX_OFF_MAX_NS = 10000;
	// longest time rounds down
	localparam int TX_OFF_MAX_CYCLES = TX_OFF_MAX_NS / CLK_PERIOD_NS;
	localparam int MON_PERIOD_NS = 1000;
	localparam int MON_PERIOD_CYCLES = MON_PERIOD_NS / CLK_PERIOD_NS;
	localparam int MON_CNT_W = 8;

	// ****************************************
	// two-wire management
	// ****************************************
	localparam logic [6:0] DEV_ADDR = 7'h50;
	localparam logic [2:0] IDX_CAUSE = 3'h0;
	localparam logic [2:0] IDX_STATUS = 3'h1;
	localparam logic [2:0] IDX_TEMP = 3'h2;
	localparam logic [2:0] IDX_BIAS = 3'h3;
	localparam logic [2:0] IDX_TXPWR = 3'h4;
	localparam logic [2:0] IDX_RXPWR = 3'h5;
	localparam logic [2:0] IDX_SUPPLY = 3'h6;
	localparam logic [2:0] IDX_CONTROL = 3'h7;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam int CTRL_SOFT_TX_OFF = 0;

	// ****************************************
	// cause bits
	// ****************************************
	localparam int NUM_CAUSES = 5;
	localparam int CAUSE_LOS = 0;
	localparam int CAUSE_TX_UNLOCK = 1;
	localparam int CAUSE_LASER_FAULT = 2;
	localparam int CAUSE_RX_UNLOCK = 3;
	localparam int CAUSE_TX_OFF = 4;

	// ****************************************
	// receive power thresholds with hysteresis
	// ****************************************
	localparam logic [7:0] LOS_ASSERT_CODE = 8'h10;
	localparam logic [7:0] LOS_DEASSERT_CODE = 8'h20;

	// ****************************************
	// unit init table
	// ****************************************
	localparam logic [1:0] UNIT_LASER = 2'h0;
	localparam logic [1:0] UNIT_LIMAMP = 2'h1;
	localparam logic [1:0] UNIT_CDR = 2'h2;
	localparam int INIT_COUNT = 6;
	localparam int INIT_IDX_W = 3;

	typedef enum {CTL_INIT, CTL_RUN} tcsp_ctl_type;
	typedef enum {TW_IDLE, TW_ADDR, TW_ADDR_ACK, TW_PTR, TW_PTR_ACK, TW_WR, TW_WR_ACK, TW_RD, TW_RD_ACK,
		TW_RD_NEXT} tcsp_tw_type;
endpackage
`default_nettype wire

//--- verilog/tcsp_cause_latch.sv
// Purpose: sticky cause bits behind the interrupt output
// Assumes: clear comes as a one-cycle pulse when the cause byte is read
// Notes: a condition still present at the clear sets its bit again
`default_nettype none
module tcsp_cause_latch
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [tcsp_pkg::NUM_CAUSES-1:0] cond_i,
	input wire logic clear_i,
	output logic [tcsp_pkg::NUM_CAUSES-1:0] cause_o,
	output logic any_o
);
	logic [tcsp_pkg::NUM_CAUSES-1:0] cause_r;
	logic [tcsp_pkg::NUM_CAUSES-1:0] cause_nxt;
	logic any_r;

	// ****************************************
	// per-bit set and clear
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < tcsp_pkg::NUM_CAUSES; g++)
		begin : g_bit
			// set wins over clear so no event is lost
			always_comb
			begin
				cause_nxt[g] = (cause_r[g] & ~clear_i) | cond_i[g]; // R8
			end
		end
	endgenerate

	// register stage
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			cause_r <= '0;
			any_r <= 1'b0;
		end
		else
		begin
			cause_r <= cause_nxt;
			any_r <= |cause_nxt; // R8
		end
	end

	assign cause_o = cause_r;
	assign any_o = any_r;
endmodule
`default_nettype wire

//--- dv/tcsp_props.sv
// Purpose: pin relations of the transceiver control block over time
// Assumes: one clock, synchronous active low reset
// Notes: bound to tcsp_top, sees its ports only
`default_nettype none
module tcsp_props
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic transmit_off_request_i,
	input wire logic deselect_i,
	input wire logic tx_unlock_i,
	input wire logic laser_fault_i,
	input wire logic rx_unlock_i,
	input wire logic [7:0] rx_power_i,
	input wire logic sda_oe_o,
	input wire logic interrupt_oe_o,
	input wire logic laser_enable_o,
	input wire logic rx_signal_lost_o,
	input wire logic module_fault_flag_o,
	input wire logic cfg_wr_o,
	input wire logic [1:0] cfg_unit_o,
	input wire logic ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);
	// six init writes back to back, then the strobe is low for one cycle
	sequence s_init_burst;
		cfg_wr_o [*6] ##1 !cfg_wr_o;
	endsequence
	sequence s_ready_up;
		##[0:1] ready_o;
	endsequence
	a_laser_off: assert property (transmit_off_request_i |=> !laser_enable_o) else $error("laser on");
	a_los_set: assert property (rx_power_i < 8'h10 |=> rx_signal_lost_o) else $error("los not set");
	a_los_clear: assert property (rx_power_i > 8'h20 |=> !rx_signal_lost_o) else $error("los not clear");
	a_los_hold: assert property ((rx_power_i >= 8'h10 && rx_power_i <= 8'h20) |=>
		rx_signal_lost_o == $past(rx_signal_lost_o)) else $error("los moved in band");
	a_fault_set: assert property ((tx_unlock_i || laser_fault_i || rx_unlock_i) |=>
		module_fault_flag_o) else $error("fault not set");
	a_fault_clear: assert property (!(tx_unlock_i || laser_fault_i || rx_unlock_i) |=>
		!module_fault_flag_o) else $error("fault not clear");
	a_deselect_quiet: assert property (deselect_i |=> !sda_oe_o) else $error("sda driven deselected");
	a_irq_cause: assert property ((tx_unlock_i || laser_fault_i || rx_unlock_i || transmit_off_request_i) |->
		##[1:3] interrupt_oe_o) else $error("no interrupt");
	a_init_burst: assert property ($rose(rst_b_i) |=> s_init_burst ##0 s_ready_up) else $error("init burst");
	// ready rises with the last init write, so no write may follow a ready seen one cycle earlier
	a_init_target: assert property (cfg_wr_o |-> cfg_unit_o <= 2'h2 && !$past(ready_o)) else $error("init target");
	a_ready_stay: assert property (ready_o |=> ready_o) else $error("ready dropped");
endmodule
bind tcsp_top tcsp_props u_props (.clock_i(clock_i), .rst_b_i(rst_b_i),
	.transmit_off_request_i(transmit_off_request_i), .deselect_i(deselect_i), .tx_unlock_i(tx_unlock_i),
	.laser_fault_i(laser_fault_i), .rx_unlock_i(rx_unlock_i), .rx_power_i(rx_power_i), .sda_oe_o(sda_oe_o),
	.interrupt_oe_o(interrupt_oe_o), .laser_enable_o(laser_enable_o), .rx_signal_lost_o(rx_signal_lost_o),
	.module_fault_flag_o(module_fault_flag_o), .cfg_wr_o(cfg_wr_o), .cfg_unit_o(cfg_unit_o), .ready_o(ready_o));
`default_nettype wire

//--- dv/tcsp_host_model.sv
// Purpose: host board side of the two-wire bus and the select pin
// Assumes: sda_i is the resolved wire level with pull-up
// Notes: slow bit timing, eight clocks a bit
`default_nettype none
module tcsp_host_model
(
	input wire logic clock_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o,
	output logic deselect_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// bus cycles
	// ****************************************
	// idle bus: both lines released high, module selected
	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
		deselect_o = 1'b0;
	end
	task tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	// select changes only with the bus idle, before any address
	task sel(input logic off);
		tick(1);
		deselect_o <= off;
		tick(4);
	endtask
	// works from idle and as a repeated start
	task start_c();
		tick(1);
		sda_low_o <= 1'b0;
		tick(2);
		scl_o <= 1'b1;
		tick(4);
		sda_low_o <= 1'b1;
		tick(4);
		scl_o <= 1'b0;
		tick(1);
	endtask
	task stop_c();
		sda_low_o <= 1'b1;
		tick(3);
		scl_o <= 1'b1;
		tick(4);
		sda_low_o <= 1'b0;
		tick(4);
	endtask
	// data changes only while scl is low
	task bit_out(input logic b);
		sda_low_o <= !b;
		tick(3);
		scl_o <= 1'b1;
		tick(4);
		scl_o <= 1'b0;
		tick(1);
	endtask
	task bit_in(output logic b);
		sda_low_o <= 1'b0;
		tick(3);
		scl_o <= 1'b1;
		tick(4);
		b = sda_i;
		scl_o <= 1'b0;
		tick(1);
	endtask
	task put_byte(input logic [7:0] v, output logic ack_n);
		for (int i = 7; i >= 0; i--)
			bit_out(v[i]);
		bit_in(ack_n);
	endtask
	task get_byte(input logic last, output logic [7:0] v);
		for (int i = 7; i >= 0; i--)
			bit_in(v[i]);
		bit_out(last);
	endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
// Purpose: self-checking bench for the transceiver control pins
// Assumes: host model drives the serial pins and the select pin, bench drives the rest
// Notes: inputs change by non-blocking assignment at rising edges
`default_nettype none
`define CHK(name, exp, act) \
	checks++; \
	if ((act) !== (exp)) \
	begin \
		$display("CHECK FAILED %s expected %0h seen %0h", name, exp, act); \
		failures++; \
	end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 1'b0;
	logic rst_b = 1'b0;
	logic tx_off = 1'b0;
	logic [2:0] flt = 3'h0;
	logic [7:0] rx_pw = 8'h80;
	logic scl, sda_low, desel, sda_oe, irq_oe, laser, rx_signal_lost, fault, cfg_wr, ready, ack;
	logic [7:0] b;
	logic [7:0] mon = 8'h5A;
	logic [1:0] cfg_unit;
	logic sda_lvl, irq_lvl;
	int u = 0;
	int failures = 0;
	int checks = 0;
	int cycles = 0;
	int n;
	wire logic sda_w = !(sda_low | sda_oe);
	// ****************************************
	// structure
	// ****************************************
	always #2 clock_i = !clock_i;
	tcsp_top DUT (.clock_i(clock_i), .rst_b_i(rst_b), .transmit_off_request_i(tx_off), .deselect_i(desel),
		.scl_i(scl), .sda_i(sda_w), .sda_o(sda_lvl), .sda_oe_o(sda_oe), .interrupt_o(irq_lvl),
		.interrupt_oe_o(irq_oe), .laser_enable_o(laser), .rx_signal_lost_o(rx_signal_lost), .module_fault_flag_o(fault),
		.tx_unlock_i(flt[2]), .laser_fault_i(flt[1]), .rx_unlock_i(flt[0]), .temp_i(mon), .bias_i(8'h11),
		.tx_power_i(8'h22), .rx_power_i(rx_pw), .supply_i(8'h33), .cfg_wr_o(cfg_wr), .cfg_unit_o(cfg_unit),
		.cfg_addr_o(), .cfg_data_o(), .ready_o(ready));
	tcsp_host_model host (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low), .deselect_o(desel));
	task end_sim();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// a hung bus cycle ends the run well past the expected length
	always @(posedge clock_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			end_sim();
		end
	end
	// ****************************************
	// scenarios
	// ****************************************
	task t_init();
		repeat (10) @(posedge clock_i);
		#1;
		`CHK("reset los", 1'b1, rx_signal_lost)
		`CHK("reset ready", 1'b0, ready)
		@(posedge clock_i);
		rst_b <= 1'b1;
		n = 0;
		repeat (12)
		begin
			@(posedge clock_i);
			#1;
			n += int'(cfg_wr);
			if (cfg_wr)
				u += int'(cfg_unit);
		end
		`CHK("init writes", 6, n)
		`CHK("init units", tcsp_pkg::UNIT_LASER * 2 + tcsp_pkg::UNIT_LIMAMP * 2 + tcsp_pkg::UNIT_CDR * 2, u)
		`CHK("open drain", 2'h0, {irq_lvl, sda_lvl})
		`CHK("ready", 1'b1, ready)
		`CHK("laser on", 1'b1, laser)
	endtask
	task t_tx_off();
		@(posedge clock_i);
		tx_off <= 1'b1;
		repeat (2) @(posedge clock_i);
		#1;
		`CHK("laser off", 1'b0, laser)
		@(posedge clock_i);
		tx_off <= 1'b0;
		repeat (2) @(posedge clock_i);
		#1;
		`CHK("laser back", 1'b1, laser)
	endtask
	// band edges: 10 and 20 keep the previous state
	task t_los();
		logic [7:0] pw [8] = '{8'h0F, 8'h15, 8'h21, 8'h15, 8'h10, 8'h20, 8'h0F, 8'h80};
		logic ex [8] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clock_i);
			rx_pw <= pw[i];
			repeat (2) @(posedge clock_i);
			#1;
			`CHK("los", ex[i], rx_signal_lost)
		end
	endtask
	task t_fault();
		for (int i = 0; i < 9; i++)
		begin
			@(posedge clock_i);
			flt <= 3'(i);
			repeat (3) @(posedge clock_i);
			#1;
			`CHK("fault", (i % 8) != 0, fault)
		end
		`CHK("irq", 1'b1, irq_oe)
	endtask
	// pointer write then repeated start and read of two bytes
	task rd2(input logic [7:0] p, output logic [7:0] b0, output logic [7:0] b1);
		host.start_c();
		host.put_byte(8'hA0, ack);
		`CHK("addr ack", 1'b0, ack)
		host.put_byte(p, ack);
		host.start_c();
		host.put_byte(8'hA1, ack);
		host.get_byte(1'b0, b0);
		host.get_byte(1'b1, b1);
		host.stop_c();
	endtask
	task t_serial();
		logic [7:0] c;
		rd2(8'h00, c, b);
		`CHK("cause", 8'h1F, c)
		`CHK("status", 8'h08, b)
		rd2(8'h01, b, c);
		`CHK("temp", 8'h5A, c)
		rd2(8'h00, c, b);
		`CHK("cause cleared", 8'h00, c)
		`CHK("irq cleared", 1'b0, irq_oe)
		// a new monitor value shows up after the next sampling tick
		mon <= 8'hA5;
		host.tick(260);
		rd2(8'h01, b, c);
		`CHK("temp new", 8'hA5, c)
		host.sel(1'b1);
		host.start_c();
		host.put_byte(8'hA0, ack);
		`CHK("deselected ack", 1'b1, ack)
		host.stop_c();
		host.sel(1'b0);
	endtask
	// soft transmit off through the control byte, then back on
	task t_soft_off();
		for (int i = 1; i >= 0; i--)
		begin
			host.start_c();
			host.put_byte(8'hA0, ack);
			host.put_byte(8'h07, ack);
			host.put_byte(8'(i), ack);
			`CHK("data ack", 1'b0, ack)
			host.stop_c();
			#1;
			`CHK("soft laser", i == 0, laser)
		end
	endtask
	task t_rereset();
		@(posedge clock_i);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock_i);
		#1;
		`CHK("reset laser", 1'b0, laser)
		`CHK("reset ready", 1'b0, ready)
		@(posedge clock_i);
		rst_b <= 1'b1;
		repeat (10) @(posedge clock_i);
		#1;
		`CHK("ready again", 1'b1, ready)
	endtask
	initial
	begin
		t_init();
		t_tx_off();
		t_los();
		t_fault();
		t_serial();
		t_soft_off();
		t_rereset();
		end_sim();
	end
endmodule
`default_nettype wire
